// ==== bench/ethlpi_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ethlpi_regs.svh"

module ethlpi_monitor #(
    parameter int LINK_UP_CYCLES = 20,
    parameter int WM_WIDTH       = 12
) (
    input wire logic                       i_clock,       // clock
    input wire logic                       i_sys_rst,     // reset
    input wire logic [11:0]                i_addr,        // address
    input wire logic [31:0]                i_wr_data,     // write data
    input wire logic                       i_wr_stb,      // write strobe
    input wire logic                       i_rd_stb,      // read strobe
    input wire logic [31:0]                o_rd_data,     // read data
    input wire logic                       i_tx_active,   // core busy
    input wire logic                       i_frame_whole, // frame buffered
    input wire logic                       i_link_up,     // link pin
    input wire logic                       i_rx_sleep,    // sleep pin
    input wire logic                       i_rx_refresh,  // refresh pin
    input wire logic                       o_tx_hold,     // hold
    input wire logic                       o_tx_start_ok, // start ok
    input wire logic                       o_csum_en,     // checksum on
    input wire logic [1:0]                 o_queue_allow, // queue allow
    input wire logic                       o_rx_lpi,      // rx low power
    input wire ethlpi_pkg::ethlpi_mii_tx_s o_mii_tx       // mii out
);
    logic [31:0] up_cnt;
    logic [1:0]  off_run;
    logic        neg, pen, pen_d, cbs_on, saw_slp, saw_ref;

    // pin-side count leads the synced one, so it undercounts only just after the link pin drops, while the synced link still reads up
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_link_up) begin
            up_cnt <= 32'h0000_0000;
        end else if (up_cnt < LINK_UP_CYCLES) begin
            up_cnt <= up_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            neg <= 1'b0;
            pen <= 1'b0;
            cbs_on <= 1'b0;
        end else if (i_wr_stb && i_addr == `ETHLPI_OFS_EEE_CTRL) begin
            neg <= i_wr_data[`ETHLPI_CTRL_NEGOTIATED];
        end else if (i_wr_stb && i_addr == `ETHLPI_OFS_PSF) begin
            pen <= i_wr_data[`ETHLPI_PSF_EN_BIT];
        end else if (i_wr_stb && i_addr == `ETHLPI_OFS_CBS_CTRL) begin
            cbs_on <= |i_wr_data[1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        pen_d <= i_sys_rst ? 1'b0 : pen;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || cbs_on) begin
            off_run <= 2'h0;
        end else if (off_run != 2'h3) begin
            off_run <= off_run + 2'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || (!i_rx_sleep && !i_rx_refresh)) begin
            saw_slp <= 1'b0;
            saw_ref <= 1'b0;
        end else begin
            if (i_rx_sleep) saw_slp <= 1'b1;
            if (i_rx_refresh && saw_slp) saw_ref <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    AST_RD_IDLE: assert property (!i_rd_stb |=> o_rd_data == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    AST_LPI_CODE: assert property ((o_mii_tx.tx_er && !o_mii_tx.tx_en)
        |-> o_mii_tx.txd == `ETHLPI_LPI_TXD && o_tx_hold)
        else $error("bad low power code on mii");
    AST_ENTER_IDLE: assert property ($rose(o_tx_hold)
        |-> !$past(i_tx_active) && !$past(i_tx_active, 2))
        else $error("low power entered while transmitting");
    AST_LINK_TIME: assert property ($rose(o_tx_hold)
        |-> up_cnt >= LINK_UP_CYCLES)
        else $error("low power entered before link settled");
    AST_NEGOTIATED: assert property ($rose(o_tx_hold) |-> neg)
        else $error("low power entered without negotiation");
    AST_WAKE_IDLE: assert property ($fell(o_tx_hold)
        |-> $past(o_mii_tx, 3) == 6'h00)
        else $error("wake did not send normal idle");
    AST_CSUM: assert property (o_csum_en |-> !(pen && pen_d))
        else $error("checksum on in partial mode");
    AST_PARTIAL: assert property ((o_tx_start_ok && !$past(i_frame_whole))
        |-> pen || pen_d)
        else $error("early start with partial mode off");
    AST_CBS_OFF: assert property (off_run == 2'h3
        |-> o_queue_allow == 2'b11)
        else $error("queue blocked with shaping off");
    AST_RX_LPI: assert property ($rose(o_rx_lpi) |-> saw_ref)
        else $error("rx low power without sleep and refresh");

    COV_ENTER: cover property ($rose(o_tx_hold));
    COV_LEAVE: cover property ($fell(o_tx_hold));
    COV_RX: cover property ($rose(o_rx_lpi));
    COV_SHAPE: cover property ($fell(o_queue_allow[0]));
endmodule // ethlpi_monitor

bind ethlpi_top ethlpi_monitor #(
    .LINK_UP_CYCLES(LINK_UP_CYCLES),
    .WM_WIDTH(WM_WIDTH)
) ethlpi_monitor_i (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data), .i_tx_active(i_tx_active),
    .i_frame_whole(i_frame_whole), .i_link_up(i_link_up),
    .i_rx_sleep(i_rx_sleep), .i_rx_refresh(i_rx_refresh),
    .o_tx_hold(o_tx_hold), .o_tx_start_ok(o_tx_start_ok),
    .o_csum_en(o_csum_en), .o_queue_allow(o_queue_allow),
    .o_rx_lpi(o_rx_lpi), .o_mii_tx(o_mii_tx)
);

`default_nettype wire

// ==== bench/ethlpi_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ethlpi_phy_model (
    input  wire logic i_link_en,     // bring link up
    input  wire logic i_partner_lpi, // far end asleep
    output logic      o_tx_clk,      // mii tx clock
    output logic      o_link_up,     // link status
    output logic      o_rx_sleep,    // sleep seen
    output logic      o_rx_refresh   // refresh seen
);
    // mii tx clock is continuous from the phy, not framed
    initial o_tx_clk = 1'b0;
    always #400 o_tx_clk = ~o_tx_clk;

    assign o_link_up = i_link_en;

    // sleep held as a level, refresh pulsed while quiet
    initial begin
        o_rx_sleep = 1'b0;
        o_rx_refresh = 1'b0;
        forever begin
            wait (i_partner_lpi);
            o_rx_sleep = 1'b1;
            while (i_partner_lpi) begin
                #2000;
                o_rx_refresh = 1'b1;
                #800;
                o_rx_refresh = 1'b0;
            end
            o_rx_sleep = 1'b0;
        end
    end
endmodule // ethlpi_phy_model

`default_nettype wire

// ==== bench/ethlpi_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ethlpi_regs.svh"

module ethlpi_top_bench;
    localparam logic [5:0] CORE = 6'h3e;
    logic        clk = 1'b0;
    logic        rst, wr_stb, rd_stb, whole, tick, link_en, p_lpi, pend;
    logic [11:0] addr, level;
    logic [31:0] wdata, rdata;
    logic [1:0]  allow, qa;
    logic        hold, start_ok, csum, rx_lpi, txclk, link, slp, rfr;
    ethlpi_pkg::ethlpi_mii_tx_s mii;
    int          errors, n_tests;

    always #50 clk = ~clk;

    ethlpi_top #(.LINK_UP_CYCLES(20)) ethlpi_top_i (
        .i_clock(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rdata),
        .i_core_tx(ethlpi_pkg::ethlpi_mii_tx_s'(CORE)),
        .i_tx_pending(pend), .i_tx_active(pend & whole), .o_tx_hold(hold),
        .i_buf_level(level), .i_frame_whole(whole),
        .o_tx_start_ok(start_ok), .o_csum_en(csum),
        .i_queue_a(ethlpi_pkg::ethlpi_queue_s'(qa)),
        .i_queue_b(ethlpi_pkg::ethlpi_queue_s'(2'b00)),
        .i_byte_tick(tick), .o_queue_allow(allow), .i_mii_tx_clk(txclk),
        .i_link_up(link), .i_rx_sleep(slp), .i_rx_refresh(rfr),
        .o_mii_tx(mii), .o_rx_lpi(rx_lpi)
    );

    ethlpi_phy_model ethlpi_phy_model_i (
        .i_link_en(link_en), .i_partner_lpi(p_lpi), .o_tx_clk(txclk),
        .o_link_up(link), .o_rx_sleep(slp), .o_rx_refresh(rfr)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // values are read before the edge's updates land
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        chk(rdata, e);
    endtask

    task automatic tick_once(input logic [1:0] q);
        @(posedge clk);
        qa <= q;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        qa <= 2'b00;
    endtask

    task automatic wait_hold(input logic v, input int lim);
        for (int k = 0; k < lim && hold !== v; k++) @(posedge clk);
    endtask

    task automatic close_out;
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        errors++;
        close_out();
    end

    initial begin
        {wr_stb, rd_stb, whole, tick, p_lpi, pend} = 6'h00;
        {addr, wdata, qa} = 46'h0;
        rst = 1'b1;
        link_en = 1'b1;
        level = 12'h122;
        errors = 0;
        n_tests = 0;
        cyc(6);
        rst <= 1'b0;
        rd(`ETHLPI_OFS_PSF, 32'h0000_0fff);
        rd(`ETHLPI_OFS_WAKE_TIME, 32'h0000_012c);
        rd(12'h0fc, 32'h0000_0000);
        wr(`ETHLPI_OFS_PSF, 32'hffff_f123);
        rd(`ETHLPI_OFS_PSF, 32'h8000_0123);
        cyc(3);
        chk(32'(start_ok), 32'h0000_0000);
        level <= 12'h123;
        cyc(4);
        chk(32'(start_ok), 32'h0000_0001);
        wr(`ETHLPI_OFS_EEE_CTRL, 32'h0000_0004);
        cyc(4);
        chk(32'(csum), 32'h0000_0000);
        wr(`ETHLPI_OFS_PSF, 32'h0000_0123);
        cyc(4);
        chk(32'(csum), 32'h0000_0001);
        chk(32'(start_ok), 32'h0000_0000);
        whole <= 1'b1;
        cyc(4);
        chk(32'(start_ok), 32'h0000_0001);
        // one sending tick costs 0x100, earns the 0x80 slope
        wr(`ETHLPI_OFS_CBS_CTRL, 32'h0000_0003);
        tick_once(2'b01);
        cyc(3);
        chk(32'(allow), 32'h0000_0002);
        rd(`ETHLPI_OFS_CREDIT_A, 32'hffff_ff80);
        tick_once(2'b10);
        cyc(3);
        chk(32'(allow), 32'h0000_0003);
        rd(`ETHLPI_OFS_CREDIT_A, 32'h0000_0000);
        wr(`ETHLPI_OFS_CBS_CTRL, 32'h0000_0000);
        wr(`ETHLPI_OFS_EEE_CTRL, 32'h0000_0001);
        cyc(200);
        chk(32'(hold), 32'h0000_0000);
        chk(32'(mii), 32'(CORE));
        wr(`ETHLPI_OFS_EEE_CTRL, 32'h0000_0003);
        for (int k = 0; k < 100 && mii !== 6'h05; k++) @(posedge clk);
        chk(32'(mii), 32'h0000_0005);
        chk(32'(hold), 32'h0000_0001);
        rd(`ETHLPI_OFS_EEE_STATUS, 32'h0000_0009);
        p_lpi <= 1'b1;
        cyc(10);
        chk(32'(rx_lpi), 32'h0000_0000);
        cyc(40);
        chk(32'(rx_lpi), 32'h0000_0001);
        pend <= 1'b1;
        cyc(100);
        chk(32'(hold), 32'h0000_0001);
        chk(32'(mii), 32'h0000_0000);
        wait_hold(1'b0, 400);
        chk(32'(hold), 32'h0000_0000);
        cyc(20);
        chk(32'(mii), 32'(CORE));
        chk(32'(rx_lpi), 32'h0000_0001);
        wr(`ETHLPI_OFS_EEE_CTRL, 32'h0000_0000);
        pend <= 1'b0;
        link_en <= 1'b0;
        cyc(5);
        link_en <= 1'b1;
        wr(`ETHLPI_OFS_EEE_CTRL, 32'h0000_0003);
        cyc(8);
        chk(32'(hold), 32'h0000_0000);
        wait_hold(1'b1, 100);
        chk(32'(hold), 32'h0000_0001);
        close_out();
    end
endmodule // ethlpi_top_bench

`default_nettype wire

// ==== hdl/ethlpi_pkg.sv ====
package ethlpi_pkg;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_LPI    = 3'b010,
        ST_WAKE   = 3'b100
    } ethlpi_tx_state_e;

    typedef struct packed {
        logic [3:0] txd;
        logic       tx_en;
        logic       tx_er;
    } ethlpi_mii_tx_s;

    typedef struct packed {
        logic       pending;
        logic       sending;
    } ethlpi_queue_s;

endpackage

// ==== hdl/ethlpi_regs.svh ====
`ifndef ETHLPI_REGS_SVH
`define ETHLPI_REGS_SVH

`define ETHLPI_CLK_HZ            10_000_000
`define ETHLPI_LINK_UP_TIME_MS   1000
`define ETHLPI_WAKE_TIME_US      30
`define ETHLPI_LINK_UP_CYCLES    (`ETHLPI_LINK_UP_TIME_MS * (`ETHLPI_CLK_HZ / 1000))
`define ETHLPI_WAKE_CYCLES       ((`ETHLPI_WAKE_TIME_US * `ETHLPI_CLK_HZ) / 1_000_000)

`define ETHLPI_OFS_EEE_CTRL      12'h000
`define ETHLPI_OFS_EEE_STATUS    12'h004
`define ETHLPI_OFS_WAKE_TIME     12'h008
`define ETHLPI_OFS_CBS_CTRL      12'h010
`define ETHLPI_OFS_IDLE_SLOPE_A  12'h014
`define ETHLPI_OFS_IDLE_SLOPE_B  12'h018
`define ETHLPI_OFS_CREDIT_A      12'h01c
`define ETHLPI_OFS_CREDIT_B      12'h020
`define ETHLPI_OFS_PSF           12'h040

`define ETHLPI_CTRL_LPI_REQ      0
`define ETHLPI_CTRL_NEGOTIATED   1
`define ETHLPI_CTRL_CSUM_REQ     2
`define ETHLPI_STAT_TX_LPI       0
`define ETHLPI_STAT_TX_WAKE      1
`define ETHLPI_STAT_RX_LPI       2
`define ETHLPI_STAT_LINK_STABLE  3
`define ETHLPI_CBS_EN_A          0
`define ETHLPI_CBS_EN_B          1
`define ETHLPI_PSF_EN_BIT        31
`define ETHLPI_PSF_WM_MSB        11

`define ETHLPI_PSF_RESET         32'h0000_0fff
`define ETHLPI_WM_RESET          12'hfff
`define ETHLPI_IDLE_SLOPE_RESET  16'h0080
`define ETHLPI_LPI_TXD           4'h1
`define ETHLPI_IDLE_TXD          4'h0
`define ETHLPI_PORT_RATE         24'sh00_0100

`endif

// ==== hdl/ethlpi_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ethlpi_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,   // system clock
    input  wire logic             i_sys_rst, // sync reset, high
    input  wire logic [WIDTH-1:0] i_async,   // foreign-domain levels
    output logic      [WIDTH-1:0] o_sync     // synchronised levels
);

    logic [WIDTH-1:0] meta;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("ethlpi_sync needs WIDTH of at least one");
        end
    endgenerate

    // first stage is read only by the second stage
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule // ethlpi_sync

`default_nettype wire

// ==== hdl/ethlpi_sync_unused_note.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== hdl/ethlpi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ethlpi_regs.svh"

module ethlpi_top #(
    parameter int LINK_UP_CYCLES = `ETHLPI_LINK_UP_CYCLES,
    parameter int WM_WIDTH       = 12
) (
    input  wire logic                  i_clock,        // 10 MHz system clock
    input  wire logic                  i_sys_rst,      // sync reset, high
    // register port
    input  wire logic [11:0]           i_addr,         // byte address
    input  wire logic [31:0]           i_wr_data,      // write data
    input  wire logic                  i_wr_stb,       // write strobe
    input  wire logic                  i_rd_stb,       // read strobe
    output logic      [31:0]           o_rd_data,      // read data, next cycle
    // core transmit side
    input  wire ethlpi_pkg::ethlpi_mii_tx_s i_core_tx, // core MII nibble
    input  wire logic                  i_tx_pending,   // a frame is queued
    input  wire logic                  i_tx_active,    // core is transmitting
    output logic                       o_tx_hold,      // core must not start
    // partial store and forward
    input  wire logic [WM_WIDTH-1:0]   i_buf_level,    // bytes buffered
    input  wire logic                  i_frame_whole,  // whole frame buffered
    output logic                       o_tx_start_ok,  // frame may start
    output logic                       o_csum_en,      // checksum offload on
    // shaped queues
    input  wire ethlpi_pkg::ethlpi_queue_s i_queue_a,  // top queue state
    input  wire ethlpi_pkg::ethlpi_queue_s i_queue_b,  // second queue state
    input  wire logic                  i_byte_tick,    // one line byte time
    output logic      [1:0]            o_queue_allow,  // queue may start
    // MII towards the phy
    input  wire logic                  i_mii_tx_clk,   // phy tx clock pin
    input  wire logic                  i_link_up,      // link status pin
    input  wire logic                  i_rx_sleep,     // phy saw sleep
    input  wire logic                  i_rx_refresh,   // phy saw refresh
    output ethlpi_pkg::ethlpi_mii_tx_s o_mii_tx,       // txd, tx_en, tx_er
    output logic                       o_rx_lpi        // partner in low power
);

    generate
        if (WM_WIDTH != 12) begin : g_bad_wm
            $error("ethlpi_top watermark field is twelve bits");
        end
        if (LINK_UP_CYCLES < 1 || LINK_UP_CYCLES > 16777215) begin : g_bad_lu
            $error("ethlpi_top LINK_UP_CYCLES out of counter range");
        end
    endgenerate

    localparam logic [23:0] LINK_UP_LAST = 24'(LINK_UP_CYCLES - 1);

    // synchronised pins
    logic [3:0] pins_s;
    logic       tx_clk_s;
    logic       link_up_s;
    logic       rx_sleep_s;
    logic       rx_refresh_s;
    logic       tx_clk_prev;
    logic       tx_fall;

    ethlpi_sync #(
        .WIDTH (4)
    ) u_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_mii_tx_clk, i_link_up, i_rx_sleep, i_rx_refresh}),
        .o_sync    (pins_s)
    );

    assign tx_clk_s     = pins_s[3];
    assign link_up_s    = pins_s[2];
    assign rx_sleep_s   = pins_s[1];
    assign rx_refresh_s = pins_s[0];

    // phy samples on the rising edge, so we change on the falling one
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            tx_clk_prev <= 1'b0;
        end else begin
            tx_clk_prev <= tx_clk_s;
        end
    end

    assign tx_fall = tx_clk_prev & ~tx_clk_s;

    // registers
    logic              lpi_req;
    logic              negotiated;
    logic              csum_req;
    logic [15:0]       wake_time;
    logic [1:0]        cbs_en;
    logic [15:0]       idle_slope_a;
    logic [15:0]       idle_slope_b;
    logic              partial_en;
    logic [WM_WIDTH-1:0] watermark;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            lpi_req      <= 1'b0;
            negotiated   <= 1'b0;
            csum_req     <= 1'b0;
            wake_time    <= 16'(`ETHLPI_WAKE_CYCLES);
            cbs_en       <= 2'h0;
            idle_slope_a <= `ETHLPI_IDLE_SLOPE_RESET;
            idle_slope_b <= `ETHLPI_IDLE_SLOPE_RESET;
            partial_en   <= 1'(`ETHLPI_PSF_RESET >> `ETHLPI_PSF_EN_BIT);
            watermark    <= `ETHLPI_WM_RESET;
        end else if (i_wr_stb) begin
            case (i_addr)
                `ETHLPI_OFS_EEE_CTRL: begin
                    lpi_req    <= i_wr_data[`ETHLPI_CTRL_LPI_REQ];
                    negotiated <= i_wr_data[`ETHLPI_CTRL_NEGOTIATED];
                    csum_req   <= i_wr_data[`ETHLPI_CTRL_CSUM_REQ];
                end
                `ETHLPI_OFS_WAKE_TIME: begin
                    wake_time <= i_wr_data[15:0];
                end
                `ETHLPI_OFS_CBS_CTRL: begin
                    cbs_en <= {i_wr_data[`ETHLPI_CBS_EN_B],
                               i_wr_data[`ETHLPI_CBS_EN_A]};
                end
                `ETHLPI_OFS_IDLE_SLOPE_A: begin
                    idle_slope_a <= i_wr_data[15:0];
                end
                `ETHLPI_OFS_IDLE_SLOPE_B: begin
                    idle_slope_b <= i_wr_data[15:0];
                end
                `ETHLPI_OFS_PSF: begin
                    partial_en <= i_wr_data[`ETHLPI_PSF_EN_BIT];
                    watermark  <= i_wr_data[`ETHLPI_PSF_WM_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // link stability timer
    logic [23:0] link_cnt;
    logic        link_stable;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            link_cnt    <= 24'h00_0000;
            link_stable <= 1'b0;
        end else if (!link_up_s) begin
            link_cnt    <= 24'h00_0000;
            link_stable <= 1'b0;
        end else if (link_cnt == LINK_UP_LAST) begin
            link_stable <= 1'b1;
        end else begin
            link_cnt <= link_cnt + 24'h00_0001;
        end
    end

    // transmit low power state machine
    ethlpi_pkg::ethlpi_tx_state_e tx_state;
    ethlpi_pkg::ethlpi_tx_state_e next_tx_state;
    logic [15:0] wake_cnt;
    logic        lpi_allowed;
    logic        tx_busy;

    assign tx_busy     = i_tx_pending | i_tx_active;
    assign lpi_allowed = lpi_req & negotiated & link_stable;

    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            ethlpi_pkg::ST_NORMAL: begin
                // enter only between frames, on a nibble boundary
                if (lpi_allowed && !tx_busy && tx_fall) begin
                    next_tx_state = ethlpi_pkg::ST_LPI;
                end
            end
            ethlpi_pkg::ST_LPI: begin
                if (!lpi_allowed || i_tx_pending) begin
                    next_tx_state = ethlpi_pkg::ST_WAKE;
                end
            end
            ethlpi_pkg::ST_WAKE: begin
                if (wake_cnt >= wake_time) begin
                    next_tx_state = ethlpi_pkg::ST_NORMAL;
                end
            end
            default: begin
                next_tx_state = ethlpi_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            tx_state <= ethlpi_pkg::ST_NORMAL;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wake_cnt <= 16'h0000;
        end else if (tx_state != ethlpi_pkg::ST_WAKE) begin
            wake_cnt <= 16'h0000;
        end else if (wake_cnt != 16'hffff) begin
            wake_cnt <= wake_cnt + 16'h0001;
        end
    end

    // frames wait rather than drop while asleep or waking
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_tx_hold <= 1'b0;
        end else begin
            o_tx_hold <= (next_tx_state != ethlpi_pkg::ST_NORMAL);
        end
    end

    // MII transmit drive
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_mii_tx <= '0;
        end else if (tx_fall) begin
            case (tx_state)
                ethlpi_pkg::ST_LPI: begin
                    o_mii_tx.txd   <= `ETHLPI_LPI_TXD;
                    o_mii_tx.tx_en <= 1'b0;
                    o_mii_tx.tx_er <= lpi_allowed;
                end
                ethlpi_pkg::ST_WAKE: begin
                    o_mii_tx.txd   <= `ETHLPI_IDLE_TXD;
                    o_mii_tx.tx_en <= 1'b0;
                    o_mii_tx.tx_er <= 1'b0;
                end
                default: begin
                    o_mii_tx <= i_core_tx;
                end
            endcase
        end
    end

    // receive indication, separate from the transmit side
    logic rx_sleep_seen;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rx_sleep_seen <= 1'b0;
            o_rx_lpi      <= 1'b0;
        end else if (!rx_sleep_s && !rx_refresh_s) begin
            rx_sleep_seen <= 1'b0;
            o_rx_lpi      <= 1'b0;
        end else begin
            if (rx_sleep_s) begin
                rx_sleep_seen <= 1'b1;
            end
            // refresh only follows a sleep from the phy
            if (rx_sleep_seen && rx_refresh_s) begin
                o_rx_lpi <= 1'b1;
            end
        end
    end

    // credit based shaping, credit in bytes with eight fraction bits
    function automatic logic signed [23:0] credit_step(
        input logic signed [23:0] cur,
        input logic [15:0]        idle,
        input ethlpi_pkg::ethlpi_queue_s q
    );
        logic signed [23:0] slope;
        slope = $signed({8'h00, idle});
        if (q.sending) begin
            credit_step = cur + slope - `ETHLPI_PORT_RATE;
        end else if (q.pending) begin
            credit_step = cur + slope;
        end else if (cur > 24'sh00_0000) begin
            // positive credit is not banked while idle
            credit_step = 24'sh00_0000;
        end else begin
            credit_step = cur + slope;
        end
        if (!q.sending && !q.pending && credit_step > 24'sh00_0000) begin
            credit_step = 24'sh00_0000;
        end
    endfunction

    logic signed [23:0] credit_a;
    logic signed [23:0] credit_b;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            credit_a <= 24'sh00_0000;
            credit_b <= 24'sh00_0000;
        end else begin
            if (!cbs_en[`ETHLPI_CBS_EN_A]) begin
                credit_a <= 24'sh00_0000;
            end else if (i_byte_tick) begin
                credit_a <= credit_step(credit_a, idle_slope_a,
                                        i_queue_a);
            end
            if (!cbs_en[`ETHLPI_CBS_EN_B]) begin
                credit_b <= 24'sh00_0000;
            end else if (i_byte_tick) begin
                credit_b <= credit_step(credit_b, idle_slope_b,
                                        i_queue_b);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_queue_allow <= 2'h3;
        end else begin
            o_queue_allow[0] <= ~cbs_en[`ETHLPI_CBS_EN_A] | ~credit_a[23];
            o_queue_allow[1] <= ~cbs_en[`ETHLPI_CBS_EN_B] | ~credit_b[23];
        end
    end

    // store and forward start decision
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_tx_start_ok <= 1'b0;
            o_csum_en     <= 1'b0;
        end else begin
            o_tx_start_ok <= (tx_state == ethlpi_pkg::ST_NORMAL) &
                             (i_frame_whole |
                              (partial_en & (i_buf_level >= watermark)));
            o_csum_en     <= csum_req & ~partial_en;
        end
    end

    // register read
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rd_data <= 32'h0000_0000;
        end else if (!i_rd_stb) begin
            o_rd_data <= 32'h0000_0000;
        end else begin
            o_rd_data <= 32'h0000_0000;
            case (i_addr)
                `ETHLPI_OFS_EEE_CTRL: begin
                    o_rd_data[`ETHLPI_CTRL_LPI_REQ]    <= lpi_req;
                    o_rd_data[`ETHLPI_CTRL_NEGOTIATED] <= negotiated;
                    o_rd_data[`ETHLPI_CTRL_CSUM_REQ]   <= csum_req;
                end
                `ETHLPI_OFS_EEE_STATUS: begin
                    o_rd_data[`ETHLPI_STAT_TX_LPI] <=
                        (tx_state == ethlpi_pkg::ST_LPI);
                    o_rd_data[`ETHLPI_STAT_TX_WAKE] <=
                        (tx_state == ethlpi_pkg::ST_WAKE);
                    o_rd_data[`ETHLPI_STAT_RX_LPI]      <= o_rx_lpi;
                    o_rd_data[`ETHLPI_STAT_LINK_STABLE] <= link_stable;
                end
                `ETHLPI_OFS_WAKE_TIME: begin
                    o_rd_data[15:0] <= wake_time;
                end
                `ETHLPI_OFS_CBS_CTRL: begin
                    o_rd_data[1:0] <= cbs_en;
                end
                `ETHLPI_OFS_IDLE_SLOPE_A: begin
                    o_rd_data[15:0] <= idle_slope_a;
                end
                `ETHLPI_OFS_IDLE_SLOPE_B: begin
                    o_rd_data[15:0] <= idle_slope_b;
                end
                `ETHLPI_OFS_CREDIT_A: begin
                    o_rd_data <= 32'($signed(credit_a));
                end
                `ETHLPI_OFS_CREDIT_B: begin
                    o_rd_data <= 32'($signed(credit_b));
                end
                `ETHLPI_OFS_PSF: begin
                    o_rd_data[`ETHLPI_PSF_EN_BIT]    <= partial_en;
                    o_rd_data[`ETHLPI_PSF_WM_MSB:0] <= watermark;
                end
                default: begin
                end
            endcase
        end
    end

endmodule // ethlpi_top

`default_nettype wire
